// ===== hw/tco_pkg.sv
package tco_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] OFS_CTRL_A   = 8'h80;
  localparam logic [7:0] OFS_CTRL_B   = 8'h84;
  localparam logic [7:0] OFS_COUNT    = 8'h88;
  localparam logic [7:0] OFS_CMP_A    = 8'h8C;
  localparam logic [7:0] OFS_CMP_B    = 8'h90;
  localparam logic [7:0] OFS_TOP_REG  = 8'h94;
  localparam logic [7:0] OFS_PORT_CFG = 8'h98;
  localparam logic [7:0] OFS_STATUS   = 8'h9C;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_CTRL_A   = 8'h00;
  localparam logic [7:0]  RST_CTRL_B   = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [3:0]  RST_PORT_CFG = 4'h0;
  localparam logic        RST_UP       = 1'b1;
  localparam logic [9:0]  RST_PRESCALE = 10'h000;
  localparam logic        RST_WAIT     = 1'b1;
  localparam logic [31:0] RST_RDATA    = 32'h00000000;

  // ==========================================================
  // Field positions
  localparam int CTRL_B_WGM_LSB = 3;
  localparam int CTRL_B_CS_LSB  = 0;
  localparam int PCFG_DATA_LSB  = 0;
  localparam int PCFG_DIR_LSB   = 2;

  // ==========================================================
  // Waveform modes and fixed tops
  localparam logic [3:0]  WGM_PC_TOGGLE_A   = 4'h9;
  localparam logic [3:0]  WGM_PC_TOGGLE_B   = 4'hB;
  localparam logic [3:0]  WGM_FAST_TOGGLE_A = 4'hE;
  localparam logic [3:0]  WGM_FAST_TOGGLE_B = 4'hF;
  localparam logic [15:0] TOP_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // ==========================================================
  // Prescaler tap masks (divide by 8, 64, 256, 1024)
  localparam logic [9:0] PRE_MASK_8    = 10'h007;
  localparam logic [9:0] PRE_MASK_64   = 10'h03F;
  localparam logic [9:0] PRE_MASK_256  = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

  typedef enum logic [2:0] {
    KIND_NORMAL, KIND_CTC, KIND_FAST, KIND_PC, KIND_PFC, KIND_RSVD
  } tco_kind_e;

  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] unused;
    logic [1:0] wgm_lo;
  } tco_ctrl_a_s;

endpackage : tco_pkg

// ===== hw/tco_timer16_compare.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Everything on sys_clk, timer tick is enable
// - Phase-frequency mode reloads compares at bottom
// - Control A: A mode 7:6, B 5:4, wave 1:0
// - Nonzero channel mode overrides normal port pin, except a PWM toggle that is not allowed
// - Pin driven only when direction bit set
// - Non-PWM: off, toggle, clear, set on match
// - Fast mode 10: clear match, set bottom
// - Fast mode 11: set match, clear bottom
// - Fast toggle only channel A, modes 14/15
// - Fast set/clear: compare equal top ignored, bottom acts
// - Dual-slope toggle only channel A, modes 9/11
// - Dual-slope 10: clear up, set down
// - Dual-slope 11: set up, clear down
// - Dual-slope counts zero to top and back
// - Dual-slope 10: compare at bottom low, at top high
module tco_timer16_compare (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        ext_clk_in,
  output var  logic        chan_a_pin_out,
  output var  logic        chan_a_pin_oe,
  output var  logic        chan_b_pin_out,
  output var  logic        chan_b_pin_oe
);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic tco_pkg::tco_kind_e kind_of(input logic [3:0] m);
    case (m)
      4'h0:                      kind_of = tco_pkg::KIND_NORMAL;
      4'h4, 4'hC:                kind_of = tco_pkg::KIND_CTC;
      4'h5, 4'h6, 4'h7, 4'hE,
      4'hF:                      kind_of = tco_pkg::KIND_FAST;
      4'h1, 4'h2, 4'h3, 4'hA,
      4'hB:                      kind_of = tco_pkg::KIND_PC;
      4'h8, 4'h9:                kind_of = tco_pkg::KIND_PFC;
      default:                   kind_of = tco_pkg::KIND_RSVD;
    endcase
  endfunction

  // ==========================================================
  // Registers
  tco_pkg::tco_ctrl_a_s ctrl_a_q;
  logic [7:0]           ctrl_b_q;
  logic [15:0]          cnt_q;
  logic [15:0]          cnt_d;
  logic                 up_q;
  logic                 up_d;
  logic [15:0]          cmp_buf_q [2];
  logic [15:0]          cmp_act_q [2];
  logic [15:0]          top_reg_q;
  logic [3:0]           pcfg_q;
  logic [9:0]           pre_q;
  logic                 ext_q;
  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic [1:0]           wave_q;
  logic [1:0]           wave_d;
  logic [1:0]           pin_q;
  logic [1:0]           oe_q;

  // ==========================================================
  // Bus decode
  wire logic        req      = avs_read | avs_write;
  wire logic        wr_acc   = avs_write & ~wait_q;
  wire logic [7:0]  adr      = {avs_address[7:2], 2'b00};
  wire logic        wr_ctl_a = wr_acc & (adr == tco_pkg::OFS_CTRL_A) & avs_byteenable[0];
  wire logic        wr_ctl_b = wr_acc & (adr == tco_pkg::OFS_CTRL_B) & avs_byteenable[0];
  wire logic        wr_cnt   = wr_acc & (adr == tco_pkg::OFS_COUNT);
  wire logic        wr_cmp_a = wr_acc & (adr == tco_pkg::OFS_CMP_A);
  wire logic        wr_cmp_b = wr_acc & (adr == tco_pkg::OFS_CMP_B);
  wire logic        wr_top   = wr_acc & (adr == tco_pkg::OFS_TOP_REG);
  wire logic        wr_pcfg  = wr_acc & (adr == tco_pkg::OFS_PORT_CFG) & avs_byteenable[0];
  wire logic [15:0] cnt_wr   = merge16(cnt_q, avs_writedata, avs_byteenable);
  wire logic [15:0] cmpa_wr  = merge16(cmp_buf_q[0], avs_writedata, avs_byteenable);
  wire logic [15:0] cmpb_wr  = merge16(cmp_buf_q[1], avs_writedata, avs_byteenable);
  wire logic [15:0] top_wr   = merge16(top_reg_q, avs_writedata, avs_byteenable);

  // ==========================================================
  // Mode decode
  wire logic [3:0] wgm = {ctrl_b_q[tco_pkg::CTRL_B_WGM_LSB +: 2], ctrl_a_q.wgm_lo};
  wire logic [2:0] cs  = ctrl_b_q[tco_pkg::CTRL_B_CS_LSB +: 3];
  wire tco_pkg::tco_kind_e kind = kind_of(wgm);
  wire logic is_fast = (kind == tco_pkg::KIND_FAST);
  wire logic is_dual = (kind == tco_pkg::KIND_PC) | (kind == tco_pkg::KIND_PFC);

  // ==========================================================
  // Timer tick (clock enable)
  logic tick;
  always_comb begin
    case (cs)
      3'h1:    tick = 1'b1;
      3'h2:    tick = (pre_q & tco_pkg::PRE_MASK_8) == tco_pkg::PRE_MASK_8;
      3'h3:    tick = (pre_q & tco_pkg::PRE_MASK_64) == tco_pkg::PRE_MASK_64;
      3'h4:    tick = (pre_q & tco_pkg::PRE_MASK_256) == tco_pkg::PRE_MASK_256;
      3'h5:    tick = pre_q == tco_pkg::PRE_MASK_1024;
      3'h6:    tick = ext_q & ~ext_clk_in;
      3'h7:    tick = ~ext_q & ext_clk_in;
      default: tick = 1'b0;
    endcase
  end

  // ==========================================================
  // Top value
  logic [15:0] top;
  always_comb begin
    case (wgm)
      4'h1, 4'h5:               top = tco_pkg::TOP_8BIT;
      4'h2, 4'h6:               top = tco_pkg::TOP_9BIT;
      4'h3, 4'h7:               top = tco_pkg::TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF:   top = cmp_act_q[0];
      4'h8, 4'hA, 4'hC, 4'hE:   top = top_reg_q;
      default:                  top = tco_pkg::TOP_MAX;
    endcase
  end

  wire logic at_top = (cnt_q == top);
  wire logic at_bot = (cnt_q == tco_pkg::RST_WORD);
  // A count at top belongs to the falling slope so a top compare in channel mode 10 stays high
  wire logic eff_up = at_bot | (up_q & ~at_top);

  // ==========================================================
  // Counter sequence
  always_comb begin
    cnt_d = cnt_q;
    up_d  = up_q;
    if (wr_cnt) begin
      cnt_d = cnt_wr;
    end else if (tick & is_dual) begin
      if (up_q) begin
        if (at_top) begin
          cnt_d = cnt_q - 16'h0001;
          up_d  = 1'b0;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end else begin
        if (at_bot) begin
          cnt_d = cnt_q + 16'h0001;
          up_d  = 1'b1;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
    end else if (tick & (kind != tco_pkg::KIND_RSVD)) begin
      cnt_d = at_top ? tco_pkg::RST_WORD : cnt_q + 16'h0001;
      up_d  = 1'b1;
    end
  end

  // ==========================================================
  // Compare buffer reload strobe
  logic upd;
  always_comb begin
    case (kind)
      tco_pkg::KIND_FAST: upd = tick & at_top;
      tco_pkg::KIND_PC:   upd = tick & at_top;
      tco_pkg::KIND_PFC:  upd = tick & at_bot;
      default:            upd = 1'b1;
    endcase
  end

  // ==========================================================
  // Output compare channels
  wire logic [1:0] com [2];
  assign com[0] = ctrl_a_q.com_a;
  assign com[1] = ctrl_a_q.com_b;
  wire logic       fast_tog_mode = (wgm == tco_pkg::WGM_FAST_TOGGLE_A) |
                                   (wgm == tco_pkg::WGM_FAST_TOGGLE_B);
  wire logic       dual_tog_mode = (wgm == tco_pkg::WGM_PC_TOGGLE_A) |
                                   (wgm == tco_pkg::WGM_PC_TOGGLE_B);
  wire logic [1:0] conn;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      wire logic match   = tick & (cnt_q == cmp_act_q[gi]);
      wire logic cmp_top = (cmp_act_q[gi] == top);
      wire logic tog_ok  = is_fast ? ((gi == 0) & fast_tog_mode) :
                           is_dual ? ((gi == 0) & dual_tog_mode) :
                           1'b1;
      assign conn[gi] = (com[gi] == 2'b01) ? tog_ok : (com[gi] != 2'b00);

      always_comb begin
        wave_d[gi] = wave_q[gi];
        case (kind)
          tco_pkg::KIND_NORMAL, tco_pkg::KIND_CTC: begin
            if (match) begin
              case (com[gi])
                2'b01:   wave_d[gi] = ~wave_q[gi];
                2'b10:   wave_d[gi] = 1'b0;
                2'b11:   wave_d[gi] = 1'b1;
                default: wave_d[gi] = wave_q[gi];
              endcase
            end
          end
          tco_pkg::KIND_FAST: begin
            if (com[gi][1]) begin
              if (tick & at_top) begin
                wave_d[gi] = ~com[gi][0];
              end else if (match & ~cmp_top) begin
                wave_d[gi] = com[gi][0];
              end
            end else if ((com[gi] == 2'b01) & tog_ok & match) begin
              wave_d[gi] = ~wave_q[gi];
            end
          end
          tco_pkg::KIND_PC, tco_pkg::KIND_PFC: begin
            if (com[gi][1] & match) begin
              wave_d[gi] = eff_up ? com[gi][0] : ~com[gi][0];
            end else if ((com[gi] == 2'b01) & tog_ok & match) begin
              wave_d[gi] = ~wave_q[gi];
            end
          end
          default: wave_d[gi] = wave_q[gi];
        endcase
      end

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          cmp_buf_q[gi] <= tco_pkg::RST_WORD;
          cmp_act_q[gi] <= tco_pkg::RST_WORD;
        end else begin
          if ((gi == 0) ? wr_cmp_a : wr_cmp_b) begin
            cmp_buf_q[gi] <= (gi == 0) ? cmpa_wr : cmpb_wr;
          end
          if (upd) begin
            cmp_act_q[gi] <= cmp_buf_q[gi];
          end
        end
      end

      // Pin follows the wave one cycle after its cause
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          wave_q[gi] <= 1'b0;
          pin_q[gi]  <= 1'b0;
          oe_q[gi]   <= 1'b0;
        end else begin
          wave_q[gi] <= wave_d[gi];
          pin_q[gi]  <= conn[gi] ? wave_d[gi] : pcfg_q[tco_pkg::PCFG_DATA_LSB + gi];
          oe_q[gi]   <= pcfg_q[tco_pkg::PCFG_DIR_LSB + gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read mux
  logic [31:0] rmux;
  always_comb begin
    case (adr)
      tco_pkg::OFS_CTRL_A:   rmux = {24'h000000, ctrl_a_q};
      tco_pkg::OFS_CTRL_B:   rmux = {24'h000000, ctrl_b_q};
      tco_pkg::OFS_COUNT:    rmux = {16'h0000, cnt_q};
      tco_pkg::OFS_CMP_A:    rmux = {16'h0000, cmp_buf_q[0]};
      tco_pkg::OFS_CMP_B:    rmux = {16'h0000, cmp_buf_q[1]};
      tco_pkg::OFS_TOP_REG:  rmux = {16'h0000, top_reg_q};
      tco_pkg::OFS_PORT_CFG: rmux = {28'h0000000, pcfg_q};
      tco_pkg::OFS_STATUS:   rmux = {27'h0000000, conn, up_q, wave_q};
      default:               rmux = 32'h00000000;
    endcase
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_a_q  <= tco_pkg::RST_CTRL_A;
      ctrl_b_q  <= tco_pkg::RST_CTRL_B;
      top_reg_q <= tco_pkg::RST_WORD;
      pcfg_q    <= tco_pkg::RST_PORT_CFG;
    end else begin
      if (wr_ctl_a) begin
        ctrl_a_q <= {avs_writedata[7:4], 2'b00, avs_writedata[1:0]};
      end
      if (wr_ctl_b) begin
        ctrl_b_q <= {3'h0, avs_writedata[4:0]};
      end
      if (wr_top) begin
        top_reg_q <= top_wr;
      end
      if (wr_pcfg) begin
        pcfg_q <= avs_writedata[3:0];
      end
    end
  end

  // ==========================================================
  // Counter, prescaler and external edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= tco_pkg::RST_WORD;
      up_q  <= tco_pkg::RST_UP;
      pre_q <= tco_pkg::RST_PRESCALE;
      ext_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      up_q  <= up_d;
      // Stopped prescaler restarts from zero
      pre_q <= (cs == 3'h0) ? tco_pkg::RST_PRESCALE : pre_q + 10'h001;
      ext_q <= ext_clk_in;
    end
  end

  // ==========================================================
  // Bus handshake
  // One wait state: capture on the first cycle, answer on the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wait_q  <= tco_pkg::RST_WAIT;
      rdata_q <= tco_pkg::RST_RDATA;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        rdata_q <= rmux;
      end
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign chan_a_pin_out  = pin_q[0];
  assign chan_a_pin_oe   = oe_q[0];
  assign chan_b_pin_out  = pin_q[1];
  assign chan_b_pin_oe   = oe_q[1];

endmodule // tco_timer16_compare
`default_nettype wire

// ===== bench/tco_timer16_compare_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tco_timer16_compare_properties (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        ext_clk_in,
  input wire logic        chan_a_pin_out,
  input wire logic        chan_a_pin_oe,
  input wire logic        chan_b_pin_out,
  input wire logic        chan_b_pin_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire logic wr_done = avs_write && !avs_waitrequest;
  // ==========================================================
  // Bus handshake
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered next cycle");
  AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  AST_RDATA_HOLD: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved while idle");
  AST_UNMAPPED_ZERO: assert property (!avs_waitrequest && avs_read
    && avs_address[7:5] != 3'h4 |-> avs_readdata == 32'h0) else $error("unmapped read not 0");
  // ==========================================================
  // Control register and pins
  AST_CTRL_RSVD: assert property (!avs_waitrequest && avs_read
    && avs_address[7:2] == 6'h20 |-> avs_readdata[31:8] == 24'h0 && avs_readdata[3:2] == 2'h0)
    else $error("control reserved bits not 0");
  AST_OE_A: assert property ($changed(chan_a_pin_oe) |->
    $past(wr_done) || $past(wr_done, 2)) else $error("oe A moved without a write");
  AST_OE_B: assert property ($changed(chan_b_pin_oe) |->
    $past(wr_done) || $past(wr_done, 2)) else $error("oe B moved without a write");
  AST_RESET_STATE: assert property ($fell(srst) |-> avs_waitrequest && !chan_a_pin_oe
    && !chan_b_pin_oe && !chan_a_pin_out && !chan_b_pin_out && avs_readdata == 32'h0)
    else $error("state after reset not cleared");
endmodule // tco_timer16_compare_properties
`default_nettype wire

// ===== bench/tco_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module tco_pin_model (
  input  wire logic sys_clk,
  input  wire logic chan_a_pin_out,
  input  wire logic chan_a_pin_oe,
  input  wire logic chan_b_pin_out,
  input  wire logic chan_b_pin_oe,
  output wire logic a_pad,
  output wire logic b_pad,
  output var  logic ext_clk_in
);
  logic [2:0] div_q;
  // ==========================================================
  // Pads pulled up while undriven
  assign a_pad = chan_a_pin_oe ? chan_a_pin_out : 1'b1;
  assign b_pad = chan_b_pin_oe ? chan_b_pin_out : 1'b1;
  initial begin
    div_q = 3'h0;
    ext_clk_in = 1'b0;
  end
  always @(posedge sys_clk) begin
    div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
    if (div_q == 3'h4) ext_clk_in <= ~ext_clk_in;
  end
endmodule // tco_pin_model
`default_nettype wire

// ===== bench/tco_timer16_compare_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tco_timer16_compare_tb;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_clk_in;
  logic        chan_a_pin_out, chan_a_pin_oe, chan_b_pin_out, chan_b_pin_oe;
  wire logic   a_pad, b_pad;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'd43432;
  logic [31:0] rd, r;
  // Wave mode, mode A, mode B, compare A, compare B, top, clock select
  int tbl[12][7] = '{'{4,1,3,15,7,15,1}, '{12,2,1,5,9,15,1}, '{14,2,2,4,15,15,1},
    '{14,3,3,4,15,15,1}, '{14,1,1,4,9,15,1}, '{15,1,1,15,9,15,1}, '{10,2,2,4,0,15,1},
    '{8,3,2,4,15,15,1}, '{9,1,1,15,9,15,1}, '{11,1,0,15,9,15,1}, '{14,2,3,4,9,15,2},
    '{10,3,2,7,3,15,6}};
  always #5 sys_clk = ~sys_clk;
  tco_timer16_compare i_tco_timer16_compare (.sys_clk, .srst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .ext_clk_in, .chan_a_pin_out, .chan_a_pin_oe, .chan_b_pin_out, .chan_b_pin_oe);
  tco_pin_model i_tco_pin_model (.sys_clk, .chan_a_pin_out, .chan_a_pin_oe,
    .chan_b_pin_out, .chan_b_pin_oe, .a_pad, .b_pad, .ext_clk_in);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic summarize();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // Reference: high cycles and edges over twenty periods
  task automatic model(input int w, ch, com, c, t, output int h, tr, p);
    int k;
    k = (w == 4 || w == 12) ? 0 : (w >= 14) ? 1 : 2;
    p = (k == 2) ? 2 * t : t + 1;
    tr = 0;
    if (com == 0 || (com == 1 && k != 0 && (ch == 1 || !(w inside {9, 11, 14, 15}))))
      h = 20 * p * ch;
    else if (com == 1) begin
      h = 10 * p;
      tr = 20;
    end
    else if (k == 0) h = (com == 3) ? 20 * p : 0;
    else begin
      h = (k == 1) ? ((c == t) ? p : c + 1) : ((c == t) ? p : 2 * c);
      tr = (h == 0 || h == p) ? 0 : 40;
      if (com == 3) h = p - h;
      h = 20 * h;
    end
  endtask
  task automatic run(input int s);
    int w, p, d, ha, hb, ta, tb, ea, eb, fa, fb;
    logic la, lb;
    w = tbl[s][0];
    d = (tbl[s][6] == 2) ? 8 : (tbl[s][6] >= 6) ? 10 : 1;
    bus(1'b1, 8'h84, 32'h0);
    bus(1'b1, 8'h88, 32'h0);
    bus(1'b1, 8'h94, 32'(tbl[s][5]));
    bus(1'b1, 8'h8C, 32'(tbl[s][3]));
    bus(1'b1, 8'h90, 32'(tbl[s][4]));
    bus(1'b1, 8'h80, 32'(tbl[s][1] << 6 | tbl[s][2] << 4 | w % 4));
    bus(1'b1, 8'h84, 32'(w / 4 << 3 | tbl[s][6]));
    model(w, 0, tbl[s][1], tbl[s][3], tbl[s][5], ea, fa, p);
    model(w, 1, tbl[s][2], tbl[s][4], tbl[s][5], eb, fb, p);
    p = p * d;
    ea = ea * d;
    eb = eb * d;
    repeat (3 * p) @(posedge sys_clk);
    ha = 0;
    hb = 0;
    ta = 0;
    tb = 0;
    la = a_pad;
    lb = b_pad;
    repeat (20 * p) begin
      @(posedge sys_clk);
      ha += a_pad;
      hb += b_pad;
      ta += (a_pad != la);
      tb += (b_pad != lb);
      la = a_pad;
      lb = b_pad;
    end
    check(32'(ha), 32'(ea));
    check(32'(hb), 32'(eb));
    check(32'(ta), 32'(fa));
    check(32'(tb), 32'(fb));
    $display("scenario %0d mode %0d done", s, w);
  endtask
  // ==========================================================
  // Timeout
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      summarize();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, 8'h80, 32'h0);
    check(rd, 32'h0);
    r = rnd();
    bus(1'b1, 8'h80, r);
    bus(1'b0, 8'h80, 32'h0);
    check(rd, r & 32'hF3);
    bus(1'b1, 8'h8C, r);
    bus(1'b0, 8'h8C, 32'h0);
    check(rd, r & 32'hFFFF);
    bus(1'b1, 8'hA0, rnd());
    bus(1'b0, 8'hA0, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 8'h80, 32'h0);
    bus(1'b1, 8'h98, 32'h5);
    repeat (3) @(posedge sys_clk);
    check(32'({chan_a_pin_oe, chan_b_pin_oe, a_pad, b_pad}), 32'hB);
    bus(1'b0, 8'h9C, 32'h0);
    check(rd, 32'h4);
    bus(1'b1, 8'h98, 32'hE);
    $display("register checks done");
    for (int s = 0; s < 12; s++) run(s);
    summarize();
  end
endmodule // tco_timer16_compare_tb
bind tco_timer16_compare tco_timer16_compare_properties i_tco_timer16_compare_properties (
  .sys_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .ext_clk_in, .chan_a_pin_out, .chan_a_pin_oe,
  .chan_b_pin_out, .chan_b_pin_oe);
`default_nettype wire
